/* lcci_map.svh */
`ifndef LCCI_MAP_SVH
`define LCCI_MAP_SVH

// register byte offsets
`define LCCI_OFF_ROUTE      8'h00
`define LCCI_OFF_RELAY      8'h04
`define LCCI_OFF_UNITS      8'h08
`define LCCI_OFF_CMD        8'h0C
`define LCCI_OFF_QSEL       8'h10
`define LCCI_OFF_LEN        8'h14
`define LCCI_OFF_APPROX     8'h18
`define LCCI_OFF_OFFSET     8'h1C
`define LCCI_OFF_POINTS     8'h20
`define LCCI_OFF_ACTIVE     8'h24
`define LCCI_OFF_STATUS     8'h28
`define LCCI_OFF_ERR        8'h2C
`define LCCI_OFF_EVT_EN     8'h30
`define LCCI_OFF_ROUTE_CHR  8'h34

// command word fields
`define LCCI_CMD_OP_HI      31
`define LCCI_CMD_OP_LO      28
`define LCCI_CMD_INP_HI     27
`define LCCI_CMD_INP_LO     26
`define LCCI_CMD_SEL_HI     25
`define LCCI_CMD_SEL_LO     23
`define LCCI_CMD_DATA_HI    15

// command opcodes
`define LCCI_OP_UNLOCK      4'h1
`define LCCI_OP_LOCK        4'h2
`define LCCI_OP_LEN         4'h3
`define LCCI_OP_CAP_MIN     4'h4
`define LCCI_OP_CAP_MAX     4'h5
`define LCCI_OP_ACTIVE      4'h6
`define LCCI_OP_APPROX      4'h7
`define LCCI_OP_OFFSET      4'h8
`define LCCI_OP_PCT         4'h9
`define LCCI_OP_INCH        4'hA
`define LCCI_OP_CM          4'hB

// status fields
`define LCCI_ST_UNLOCK      0
`define LCCI_ST_EVT_LO      4
`define LCCI_ST_EVT_HI      7
`define LCCI_ST_CNT_LO      8
`define LCCI_ST_CNT_HI      11

// encodings and reset values
`define LCCI_ROUTE_NULL     3'h4
`define LCCI_ROUTE_MAX      3'h4
`define LCCI_UNITS_PCT      2'h0
`define LCCI_UNITS_INCH     2'h1
`define LCCI_UNITS_CM       2'h2
`define LCCI_RST_UNITS      2'h0
`define LCCI_RST_ACTIVE     2'h0
`define LCCI_SEL_MIN        3'h1
`define LCCI_SEL_MAX        3'h4
`define LCCI_CHR_DASH       8'h2D
`define LCCI_CHR_A          8'h41
`define LCCI_CHR_ONE        8'h31
`define LCCI_ERRQ_DEPTH     4'hA
`define LCCI_ERR_TEXT_MAX   8'h50

// error magnitudes (reported negated) and category thresholds
`define LCCI_ERR_UNKNOWN    16'h0065
`define LCCI_ERR_RANGE      16'h0069
`define LCCI_ERR_PCT_LEN    16'h006B
`define LCCI_ERR_PASSCODE   16'h006C
`define LCCI_ERR_LOCKED     16'h006E
`define LCCI_ERR_OVERFLOW   16'h0130
`define LCCI_ERR_INCOMPLETE 16'h0131
`define LCCI_ERR_SEL_RANGE  16'h0134
`define LCCI_ERR_INPUT_ID   16'h0137
`define LCCI_CAT_QUERY      16'h00C8
`define LCCI_CAT_EXEC       16'h012C
`define LCCI_CAT_DEVICE     16'h0190

`endif

/* lcci_pkg.sv */
package lcci_pkg;

  typedef logic [3:0][15:0] lcci_lvl_t;

  typedef struct packed {
    logic [15:0] len;
    logic [15:0] approx;
    logic [15:0] offs;
    logic [15:0] lo;
    logic [15:0] hi;
    logic        have_lo;
    logic        have_hi;
  } lcci_slot_t;

  typedef enum logic [1:0] {
    LCCI_SYNC0,
    LCCI_SYNC1,
    LCCI_LOAD,
    LCCI_RUN
  } lcci_boot_t;

  typedef struct packed {
    logic               hreadyout;
    logic [31:0]        hrdata;
    logic               pend;
    logic               pend_wr;
    logic [7:0]         pend_addr;
    lcci_boot_t         boot;
    logic [3:0][2:0]    route;
    logic               relay;
    logic [1:0]         units;
    logic               unlocked;
    lcci_slot_t [15:0]  cal;
    logic [3:0][1:0]    active;
    logic [1:0]         q_inp;
    logic [1:0]         q_slot;
    logic [9:0][15:0]   errq;
    logic [3:0]         errcnt;
    logic [3:0]         evt;
    logic [3:0]         evt_en;
    logic               summary;
    logic               beep;
    logic               beep_two;
    logic               nv_wr;
    logic [1:0]         nvs1;
    logic [1:0]         nvs2;
    lcci_lvl_t          smp1;
    lcci_lvl_t          smp2;
  } lcci_st_t;

endpackage

/* lcci_top.sv */
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "lcci_map.svh"

// Contract
// - each channel routes one of four inputs or null; null stops measuring
// - routing query gives one character: input letter or dash
// - relay routing 0 puts contacts on channels 1-2, 1 on 3-4
// - four calibration slots per input, selected 1 to 4
// - correct passcode unlocks calibration until lock or reset
// - locked calibration refuses changes but answers queries
// - active length accepted only in inches or centimetres
// - capture beeps once, twice when lower above upper or reverse
// - only slots with both capture points may become active
// - active slot query returns a digit 1 to 4
// - approximate and offset factors stored and returned per slot
// - remote units: percent 0, inches 1, centimetres 2
// - remote units survive power cycles via non-volatile store
// - three shortcut commands set percent, inches, centimetres
// - errors beep, queue code, set enabled category bits
// - errors are negative three-digit codes, text at most 80 chars
// - queue of ten errors, oldest first, removed on read
// - eleventh error overwrites newest with overflow code, then stops
// - reading an empty queue returns code zero
// - category bits stay set until cleared by software
// - changing calibration while locked enqueues code 110
module lcci_top #(
  parameter logic [15:0] PASSCODE = 16'h5A5A
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire lcci_pkg::lcci_lvl_t sens_level,
  input  wire logic [1:0]        nv_units,
  output logic [3:0][2:0]        chan_input,
  output logic                   relay_sel,
  output logic [1:0]             units,
  output logic                   cal_unlocked,
  output logic                   beep,
  output logic                   beep_double,
  output logic                   nv_units_wr,
  output logic                   event_summary
);

  lcci_pkg::lcci_st_t st_r;
  lcci_pkg::lcci_st_t st_nxt;
  logic [15:0]        ecode;
  logic               err_push;
  logic [3:0]         cmd_op;
  logic [1:0]         cmd_inp;
  logic [2:0]         cmd_sel;
  logic [15:0]        cmd_data;
  logic [3:0]         cmd_idx;
  logic               sel_ok;
  logic [3:0]         q_idx;
  logic               cmd_hit;
  logic               evt_clr_hit;

  function automatic logic [1:0] err_cat(input logic [15:0] mag);
    if (mag >= `LCCI_CAT_DEVICE) begin
      err_cat = 2'h3;
    end else if (mag >= `LCCI_CAT_EXEC) begin
      err_cat = 2'h2;
    end else if (mag >= `LCCI_CAT_QUERY) begin
      err_cat = 2'h1;
    end else begin
      err_cat = 2'h0;
    end
  endfunction

  function automatic logic [7:0] route_chr(input logic [2:0] code);
    route_chr = (code == `LCCI_ROUTE_NULL) ? `LCCI_CHR_DASH : `LCCI_CHR_A + {5'h00, code};
  endfunction

  function automatic lcci_pkg::lcci_st_t push_err(input lcci_pkg::lcci_st_t s, input logic [15:0] mag);
    lcci_pkg::lcci_st_t r;
    logic [1:0]         c;
    r = s;
    c = err_cat(mag);
    if (s.errcnt >= `LCCI_ERRQ_DEPTH) begin
      r.errq[9] = `LCCI_ERR_OVERFLOW;
      // overflow itself is an execution error
      if (s.evt_en[err_cat(`LCCI_ERR_OVERFLOW)]) begin
        r.evt[err_cat(`LCCI_ERR_OVERFLOW)] = 1'b1;
      end
    end else begin
      r.errq[s.errcnt] = mag;
      r.errcnt = s.errcnt + 4'h1;
    end
    r.beep = 1'b1;
    if (s.evt_en[c]) begin
      r.evt[c] = 1'b1;
    end
    push_err = r;
  endfunction

  assign cmd_op   = hwdata[`LCCI_CMD_OP_HI:`LCCI_CMD_OP_LO];
  assign cmd_inp  = hwdata[`LCCI_CMD_INP_HI:`LCCI_CMD_INP_LO];
  assign cmd_sel  = hwdata[`LCCI_CMD_SEL_HI:`LCCI_CMD_SEL_LO];
  assign cmd_data = hwdata[`LCCI_CMD_DATA_HI:0];
  assign sel_ok   = (cmd_sel >= `LCCI_SEL_MIN) && (cmd_sel <= `LCCI_SEL_MAX);
  assign cmd_idx  = {cmd_inp, 2'(cmd_sel - `LCCI_SEL_MIN)};
  assign q_idx    = {st_r.q_inp, st_r.q_slot};
  assign cmd_hit  = st_r.pend && st_r.pend_wr && (st_r.pend_addr == `LCCI_OFF_CMD);
  assign evt_clr_hit = st_r.pend && st_r.pend_wr && (st_r.pend_addr == `LCCI_OFF_STATUS);
  assign err_push = (ecode != 16'h0000);

  always_comb begin
    st_nxt = st_r;
    ecode = 16'h0000;
    st_nxt.beep = 1'b0;
    st_nxt.beep_two = 1'b0;
    st_nxt.nv_wr = 1'b0;
    // pins cross in: two flops before use
    st_nxt.smp1 = sens_level;
    st_nxt.smp2 = st_r.smp1;
    st_nxt.nvs1 = nv_units;
    st_nxt.nvs2 = st_r.nvs1;
    // stored units reloaded once the strap sync has settled
    case (st_r.boot)
      lcci_pkg::LCCI_SYNC0: st_nxt.boot = lcci_pkg::LCCI_SYNC1;
      lcci_pkg::LCCI_SYNC1: st_nxt.boot = lcci_pkg::LCCI_LOAD;
      lcci_pkg::LCCI_LOAD: begin
        if (st_r.nvs2 <= `LCCI_UNITS_CM) begin
          st_nxt.units = st_r.nvs2;
        end
        st_nxt.boot = lcci_pkg::LCCI_RUN;
      end
      lcci_pkg::LCCI_RUN: st_nxt.boot = lcci_pkg::LCCI_RUN;
      default: st_nxt.boot = lcci_pkg::LCCI_SYNC0;
    endcase
    // one wait state so a read always sees the previous write
    if (hsel && htrans[1] && hready && !st_r.pend) begin
      st_nxt.pend = 1'b1;
      st_nxt.pend_wr = hwrite;
      st_nxt.pend_addr = haddr[7:0];
      st_nxt.hreadyout = 1'b0;
    end
    if (st_r.pend) begin
      st_nxt.pend = 1'b0;
      st_nxt.hreadyout = 1'b1;
      st_nxt.hrdata = 32'h0000_0000;
      if (st_r.pend_wr) begin
        case (st_r.pend_addr)
          `LCCI_OFF_ROUTE: begin
            for (int c = 0; c < 4; c++) begin
              if (hwdata[c*4 +: 3] <= `LCCI_ROUTE_MAX) begin
                st_nxt.route[c] = hwdata[c*4 +: 3];
              end else begin
                ecode = `LCCI_ERR_INPUT_ID;
              end
            end
          end
          `LCCI_OFF_RELAY: st_nxt.relay = hwdata[0];
          `LCCI_OFF_UNITS: begin
            if (hwdata[1:0] <= `LCCI_UNITS_CM && !(|hwdata[31:2])) begin
              st_nxt.units = hwdata[1:0];
              st_nxt.nv_wr = 1'b1;
            end else begin
              ecode = `LCCI_ERR_RANGE;
            end
          end
          `LCCI_OFF_QSEL: begin
            // query select: input in [1:0], selection in [4:2]
            if ((hwdata[4:2] >= `LCCI_SEL_MIN) && (hwdata[4:2] <= `LCCI_SEL_MAX)) begin
              st_nxt.q_inp = hwdata[1:0];
              st_nxt.q_slot = 2'(hwdata[4:2] - `LCCI_SEL_MIN);
            end else begin
              ecode = `LCCI_ERR_SEL_RANGE;
            end
          end
          `LCCI_OFF_STATUS: begin
            st_nxt.evt = st_r.evt & ~hwdata[`LCCI_ST_EVT_HI:`LCCI_ST_EVT_LO];
          end
          `LCCI_OFF_EVT_EN: st_nxt.evt_en = hwdata[3:0];
          `LCCI_OFF_CMD: begin
            case (cmd_op)
              `LCCI_OP_UNLOCK: begin
                if (cmd_data == PASSCODE) begin
                  st_nxt.unlocked = 1'b1;
                end else begin
                  ecode = `LCCI_ERR_PASSCODE;
                end
              end
              `LCCI_OP_LOCK: st_nxt.unlocked = 1'b0;
              `LCCI_OP_PCT, `LCCI_OP_INCH, `LCCI_OP_CM: begin
                st_nxt.units = 2'(cmd_op - `LCCI_OP_PCT);
                st_nxt.nv_wr = 1'b1;
              end
              `LCCI_OP_LEN, `LCCI_OP_CAP_MIN, `LCCI_OP_CAP_MAX,
              `LCCI_OP_ACTIVE, `LCCI_OP_APPROX, `LCCI_OP_OFFSET: begin
                if (!sel_ok) begin
                  ecode = `LCCI_ERR_SEL_RANGE;
                end else if (!st_r.unlocked) begin
                  ecode = `LCCI_ERR_LOCKED;
                end else begin
                  case (cmd_op)
                    `LCCI_OP_LEN: begin
                      if (st_r.units == `LCCI_UNITS_PCT) begin
                        ecode = `LCCI_ERR_PCT_LEN;
                      end else begin
                        st_nxt.cal[cmd_idx].len = cmd_data;
                      end
                    end
                    `LCCI_OP_CAP_MIN: begin
                      // two beeps when crossing stored upper
                      st_nxt.beep = 1'b1;
                      st_nxt.beep_two = st_r.cal[cmd_idx].have_hi &&
                                        (st_r.smp2[cmd_inp] > st_r.cal[cmd_idx].hi);
                      st_nxt.cal[cmd_idx].lo = st_r.smp2[cmd_inp];
                      st_nxt.cal[cmd_idx].have_lo = 1'b1;
                    end
                    `LCCI_OP_CAP_MAX: begin
                      // two beeps when under stored lower
                      st_nxt.beep = 1'b1;
                      st_nxt.beep_two = st_r.cal[cmd_idx].have_lo &&
                                        (st_r.smp2[cmd_inp] < st_r.cal[cmd_idx].lo);
                      st_nxt.cal[cmd_idx].hi = st_r.smp2[cmd_inp];
                      st_nxt.cal[cmd_idx].have_hi = 1'b1;
                    end
                    `LCCI_OP_ACTIVE: begin
                      if (st_r.cal[cmd_idx].have_lo && st_r.cal[cmd_idx].have_hi) begin
                        st_nxt.active[cmd_inp] = cmd_idx[1:0];
                      end else begin
                        ecode = `LCCI_ERR_INCOMPLETE;
                      end
                    end
                    `LCCI_OP_APPROX: st_nxt.cal[cmd_idx].approx = cmd_data;
                    `LCCI_OP_OFFSET: st_nxt.cal[cmd_idx].offs = cmd_data;
                    default: ecode = `LCCI_ERR_UNKNOWN;
                  endcase
                end
              end
              default: ecode = `LCCI_ERR_UNKNOWN;
            endcase
          end
          default: ;
        endcase
      end else begin
        case (st_r.pend_addr)
          `LCCI_OFF_ROUTE: begin
            for (int c = 0; c < 4; c++) begin
              st_nxt.hrdata[c*4 +: 3] = st_r.route[c];
            end
          end
          `LCCI_OFF_ROUTE_CHR: begin
            for (int c = 0; c < 4; c++) begin
              st_nxt.hrdata[c*8 +: 8] = route_chr(st_r.route[c]);
            end
          end
          `LCCI_OFF_RELAY: st_nxt.hrdata[0] = st_r.relay;
          `LCCI_OFF_UNITS: st_nxt.hrdata[1:0] = st_r.units;
          `LCCI_OFF_QSEL: st_nxt.hrdata[4:0] = {3'({1'b0, st_r.q_slot}) + 3'h1, st_r.q_inp};
          `LCCI_OFF_LEN: st_nxt.hrdata[15:0] = st_r.cal[q_idx].len;
          `LCCI_OFF_APPROX: st_nxt.hrdata[15:0] = st_r.cal[q_idx].approx;
          `LCCI_OFF_OFFSET: st_nxt.hrdata[15:0] = st_r.cal[q_idx].offs;
          `LCCI_OFF_POINTS: st_nxt.hrdata = {st_r.cal[q_idx].hi, st_r.cal[q_idx].lo};
          `LCCI_OFF_ACTIVE: begin
            for (int i = 0; i < 4; i++) begin
              st_nxt.hrdata[i*8 +: 8] = `LCCI_CHR_ONE + {6'h00, st_r.active[i]};
            end
          end
          `LCCI_OFF_STATUS: begin
            st_nxt.hrdata[`LCCI_ST_UNLOCK] = st_r.unlocked;
            st_nxt.hrdata[`LCCI_ST_EVT_HI:`LCCI_ST_EVT_LO] = st_r.evt;
            st_nxt.hrdata[`LCCI_ST_CNT_HI:`LCCI_ST_CNT_LO] = st_r.errcnt;
          end
          `LCCI_OFF_EVT_EN: st_nxt.hrdata[3:0] = st_r.evt_en;
          `LCCI_OFF_ERR: begin
            if (st_r.errcnt != 4'h0) begin
              st_nxt.hrdata = 32'h0000_0000 - {16'h0000, st_r.errq[0]};
              for (int k = 0; k < 9; k++) begin
                st_nxt.errq[k] = st_r.errq[k+1];
              end
              st_nxt.errq[9] = 16'h0000;
              st_nxt.errcnt = st_r.errcnt - 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
    // errors queued after any clear, so a set wins
    if (err_push) begin
      st_nxt = push_err(st_nxt, ecode);
    end
    st_nxt.summary = |st_nxt.evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.hreadyout <= 1'b1;
      st_r.boot <= lcci_pkg::LCCI_SYNC0;
      st_r.unlocked <= 1'b0;
      st_r.units <= `LCCI_RST_UNITS;
      for (int c = 0; c < 4; c++) begin
        st_r.route[c] <= `LCCI_ROUTE_NULL;
        st_r.active[c] <= `LCCI_RST_ACTIVE;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout     = st_r.hreadyout;
  assign hresp         = 1'b0;
  assign hrdata        = st_r.hrdata;
  assign chan_input    = st_r.route;
  assign relay_sel     = st_r.relay;
  assign units         = st_r.units;
  assign cal_unlocked  = st_r.unlocked;
  assign beep          = st_r.beep;
  assign beep_double   = st_r.beep_two;
  assign nv_units_wr   = st_r.nv_wr;
  assign event_summary = st_r.summary;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_lock_guard: assert property (!st_r.unlocked |=> $stable(st_r.cal))
    else $error("calibration changed while locked");
  a_locked_error: assert property (cmd_hit && !st_r.unlocked && sel_ok && cmd_op == `LCCI_OP_APPROX
    |=> st_r.beep && (st_r.errcnt == $past(st_r.errcnt) + 4'h1 || $past(st_r.errcnt) == 4'hA))
    else $error("locked change did not queue an error");
  a_queue_bound: assert property (st_r.errcnt <= `LCCI_ERRQ_DEPTH)
    else $error("error queue above ten");
  a_overflow_code: assert property (st_r.errcnt == 4'hA && err_push
    |=> st_r.errq[9] == `LCCI_ERR_OVERFLOW && st_r.errcnt == 4'hA)
    else $error("overflow code not stored");
  a_empty_zero: assert property (st_r.pend && !st_r.pend_wr && st_r.pend_addr == `LCCI_OFF_ERR &&
    st_r.errcnt == 4'h0 |=> st_r.hreadyout && st_r.hrdata == 32'h0000_0000)
    else $error("empty queue read not zero");
  a_pct_length: assert property (cmd_hit && cmd_op == `LCCI_OP_LEN && st_r.units == `LCCI_UNITS_PCT
    |=> $stable(st_r.cal) ##0 st_r.beep)
    else $error("length accepted in percent");
  a_units_legal: assert property (st_r.units != 2'h3)
    else $error("illegal units code");
  a_active_whole: assert property (cmd_hit && cmd_op == `LCCI_OP_ACTIVE &&
    !(st_r.cal[cmd_idx].have_lo && st_r.cal[cmd_idx].have_hi) |=> $stable(st_r.active))
    else $error("incomplete slot made active");
  a_evt_sticky: assert property (!evt_clr_hit |=> (st_r.evt & $past(st_r.evt)) == $past(st_r.evt))
    else $error("category bit dropped without clear");
  a_wait_state: assert property (hsel && htrans[1] && hready && !st_r.pend
    |=> !st_r.hreadyout ##1 st_r.hreadyout)
    else $error("data phase not two cycles");

  c_unlock: cover property (!st_r.unlocked ##1 st_r.unlocked);
  c_double_beep: cover property (st_r.beep_two);
  c_overflow: cover property (st_r.errcnt == 4'hA && err_push);
  c_active_set: cover property (cmd_hit && cmd_op == `LCCI_OP_ACTIVE && st_r.unlocked);

endmodule

/* lcci_far_end.sv */
`timescale 1ns/1ps
module lcci_far_end (
  input  wire logic                hclk,
  input  wire logic                nv_units_wr,
  input  wire logic [1:0]          units,
  output logic [1:0]               nv_units,
  input  wire lcci_pkg::lcci_lvl_t lvl_set,
  output lcci_pkg::lcci_lvl_t      sens_level
);
  initial nv_units = 2'h2;
  always @(posedge hclk) begin
    if (nv_units_wr === 1'b1) begin
      nv_units <= units;
    end
  end
  // sensor levels set directly by the bench
  assign sens_level = lvl_set;
endmodule

/* tb_lcci_top.sv */
`timescale 1ns/1ps
`include "lcci_map.svh"
module tb_lcci_top;
  logic                hclk = 1'b0;
  logic                hresetn = 1'b0;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = 32'h0000_0000;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = 32'h0000_0000;
  logic                hready, beep, beep_double, nv_units_wr, event_summary, relay_sel, cal_unlocked;
  logic [31:0]         hrdata, q;
  logic [1:0]          nv_units, units;
  logic [3:0][2:0]     chan_input;
  lcci_pkg::lcci_lvl_t lvl = '0;
  lcci_pkg::lcci_lvl_t sens_level;
  int                  err_total = 0, n_compared = 0, nbeep = 0, ndbl = 0;

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    nbeep <= nbeep + int'(beep === 1'b1);
    ndbl <= ndbl + int'(beep_double === 1'b1);
  end

  lcci_top #(.PASSCODE(16'h5A5A)) i_lcci_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(), .hrdata(hrdata), .sens_level(sens_level), .nv_units(nv_units), .chan_input(chan_input),
    .relay_sel(relay_sel), .units(units), .cal_unlocked(cal_unlocked), .beep(beep),
    .beep_double(beep_double), .nv_units_wr(nv_units_wr), .event_summary(event_summary));
  lcci_far_end i_lcci_far_end (.hclk(hclk), .nv_units_wr(nv_units_wr), .units(units), .nv_units(nv_units),
    .lvl_set(lvl), .sens_level(sens_level));

  function automatic logic [31:0] cw(input logic [3:0] op, input logic [1:0] inp, input logic [2:0] sel,
                                     input logic [15:0] d);
    return {op, inp, sel, 7'h00, d};
  endfunction
  // negative error code as read back
  function automatic logic [31:0] ec(input logic [15:0] m);
    return 32'h0000_0000 - {16'h0000, m};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial begin
    int b;
    int d;
    rst();
    rd(`LCCI_OFF_STATUS, 32'h0000_0000);
    rd(`LCCI_OFF_ERR, 32'h0000_0000);
    rd(`LCCI_OFF_ROUTE_CHR, 32'h2D2D_2D2D);
    rd(`LCCI_OFF_ACTIVE, 32'h3131_3131);
    chk(32'(units), 32'h0000_0002);
    $display("test reset done");
    wr(`LCCI_OFF_ROUTE, 32'h0000_4110);
    rd(`LCCI_OFF_ROUTE_CHR, 32'h2D42_4241);
    chk(32'(chan_input), 32'h0000_0848);
    b = nbeep;
    wr(`LCCI_OFF_ROUTE, 32'h0000_4115);
    @(posedge hclk);
    chk(nbeep - b, 1);
    rd(`LCCI_OFF_ROUTE, 32'h0000_4110);
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_INPUT_ID));
    for (int i = 1; i >= 0; i--) begin
      wr(`LCCI_OFF_RELAY, i);
      rd(`LCCI_OFF_RELAY, i);
      chk(32'(relay_sel), i);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`LCCI_OFF_UNITS, i);
      rd(`LCCI_OFF_UNITS, i);
    end
    wr(`LCCI_OFF_UNITS, 32'h0000_0003);
    rd(`LCCI_OFF_UNITS, 32'h0000_0002);
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_RANGE));
    for (int i = 0; i < 3; i++) begin
      wr(`LCCI_OFF_CMD, cw(`LCCI_OP_PCT + 4'(i), 2'h0, 3'h0, 16'h0000));
      chk(32'(units), i);
    end
    $display("test routing and units done");
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_APPROX, 2'h0, 3'h1, 16'h1234));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_LOCKED));
    wr(`LCCI_OFF_QSEL, 32'h0000_0004);
    rd(`LCCI_OFF_APPROX, 32'h0000_0000);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_UNLOCK, 2'h0, 3'h0, 16'hA5A5));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_PASSCODE));
    chk(32'(cal_unlocked), 32'h0000_0000);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_UNLOCK, 2'h0, 3'h0, 16'h5A5A));
    chk(32'(cal_unlocked), 32'h0000_0001);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_APPROX, 2'h1, 3'h2, 16'h00AA));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_OFFSET, 2'h1, 3'h2, 16'h0055));
    wr(`LCCI_OFF_QSEL, 32'h0000_0009);
    rd(`LCCI_OFF_APPROX, 32'h0000_00AA);
    rd(`LCCI_OFF_OFFSET, 32'h0000_0055);
    wr(`LCCI_OFF_QSEL, 32'h0000_000D);
    rd(`LCCI_OFF_APPROX, 32'h0000_0000);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_PCT, 2'h0, 3'h0, 16'h0000));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_LEN, 2'h1, 3'h2, 16'h0064));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_PCT_LEN));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_INCH, 2'h0, 3'h0, 16'h0000));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_LEN, 2'h1, 3'h2, 16'h0064));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_LEN, 2'h1, 3'h5, 16'h0064));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_SEL_RANGE));
    wr(`LCCI_OFF_QSEL, 32'h0000_0009);
    rd(`LCCI_OFF_LEN, 32'h0000_0064);
    b = nbeep;
    d = ndbl;
    lvl[2] <= 16'h0100;
    repeat (3) @(posedge hclk);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_CAP_MIN, 2'h2, 3'h1, 16'h0000));
    lvl[2] <= 16'h0080;
    repeat (3) @(posedge hclk);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_CAP_MAX, 2'h2, 3'h1, 16'h0000));
    @(posedge hclk);
    chk(nbeep - b, 2);
    chk(ndbl - d, 1);
    wr(`LCCI_OFF_QSEL, 32'h0000_0006);
    rd(`LCCI_OFF_POINTS, 32'h0080_0100);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_ACTIVE, 2'h2, 3'h2, 16'h0000));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_INCOMPLETE));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_CAP_MIN, 2'h2, 3'h3, 16'h0000));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_CAP_MAX, 2'h2, 3'h3, 16'h0000));
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_ACTIVE, 2'h2, 3'h3, 16'h0000));
    rd(`LCCI_OFF_ACTIVE, 32'h3133_3131);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_LOCK, 2'h0, 3'h0, 16'h0000));
    chk(32'(cal_unlocked), 32'h0000_0000);
    wr(`LCCI_OFF_CMD, cw(`LCCI_OP_OFFSET, 2'h1, 3'h2, 16'h0011));
    rd(`LCCI_OFF_ERR, ec(`LCCI_ERR_LOCKED));
    wr(`LCCI_OFF_QSEL, 32'h0000_0009);
    rd(`LCCI_OFF_OFFSET, 32'h0000_0055);
    $display("test calibration done");
    rst();
    chk(32'(units), 32'h0000_0001);
    rd(`LCCI_OFF_STATUS, 32'h0000_0000);
    wr(`LCCI_OFF_CMD, 32'h0000_0000);
    rd(`LCCI_OFF_STATUS, 32'h0000_0100);
    chk(32'(event_summary), 32'h0000_0000);
    wr(`LCCI_OFF_EVT_EN, 32'h0000_000F);
    for (int i = 0; i < 10; i++) begin
      wr(`LCCI_OFF_CMD, i == 0 ? cw(`LCCI_OP_APPROX, 2'h0, 3'h1, 16'h0000) : 32'h0000_0000);
    end
    rd(`LCCI_OFF_STATUS, 32'h0000_0A50);
    chk(32'(event_summary), 32'h0000_0001);
    for (int i = 0; i < 11; i++) begin
      rd(`LCCI_OFF_ERR, i == 10 ? 32'h0000_0000 : i == 9 ? ec(`LCCI_ERR_OVERFLOW) :
         i == 1 ? ec(`LCCI_ERR_LOCKED) : ec(`LCCI_ERR_UNKNOWN));
    end
    rd(`LCCI_OFF_STATUS, 32'h0000_0050);
    wr(`LCCI_OFF_STATUS, 32'h0000_00F0);
    rd(`LCCI_OFF_STATUS, 32'h0000_0000);
    chk(32'(event_summary), 32'h0000_0000);
    $display("test error queue done");
    results();
  end
endmodule
